// ### rtl/spi_opt_pkg.sv
// Constants for the SPI option control and bit-rate generator block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package spi_opt_pkg;
   localparam logic [3:0] OPTION_CONTROL_ADDR = 4'h0;
   localparam logic [3:0] BIT_RATE_ADDR       = 4'h4;
   localparam logic [3:0] MODE_STATUS_ADDR    = 4'h8;
   localparam logic [7:0] OPTION_RESET        = 8'h00;
   localparam logic [7:0] BIT_RATE_RESET      = 8'h00;
   localparam logic [7:0] OPTION_WMASK        = 8'h1B;
   localparam logic [7:0] BIT_RATE_WMASK      = 8'h77;
   localparam int FAULT_EN_BIT   = 4;
   localparam int DRIVE_EN_BIT   = 3;
   localparam int WAIT_STOP_BIT  = 1;
   localparam int SINGLE_WIRE_BIT = 0;
   localparam int PRESCALE_LSB   = 4;
   localparam int RATE_LSB       = 0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/spi_opt_ctrl.sv
// SPI optional-feature control and master bit-rate generator.
// Assumes bus-clock registers over AXI4-Lite; pins come from outside
// and are synchronised here; master/select-enable bits come from logic
// on the same clock.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module spi_opt_ctrl
   import spi_opt_pkg::*;
(
   input  wire logic        I_MCLK,          // Bus clock
   input  wire logic        I_RESET_N,       // Async reset, active low
   input  wire logic [3:0]  I_AWADDR,        // Write address
   input  wire logic        I_AWVALID,       // Write address valid
   output logic             O_AWREADY,       // Write address ready
   input  wire logic [31:0] I_WDATA,         // Write data
   input  wire logic [3:0]  I_WSTRB,         // Write strobes
   input  wire logic        I_WVALID,        // Write data valid
   output logic             O_WREADY,        // Write data ready
   output logic [1:0]       O_BRESP,         // Write response
   output logic             O_BVALID,        // Write response valid
   input  wire logic        I_BREADY,        // Write response ready
   input  wire logic [3:0]  I_ARADDR,        // Read address
   input  wire logic        I_ARVALID,       // Read address valid
   output logic             O_ARREADY,       // Read address ready
   output logic [31:0]      O_RDATA,         // Read data
   output logic [1:0]       O_RRESP,         // Read response
   output logic             O_RVALID,        // Read data valid
   input  wire logic        I_RREADY,        // Read data ready
   input  wire logic        I_MASTER_SELECT, // 1 master, 0 slave
   input  wire logic        I_SELECT_OUT_EN, // Select output enable
   input  wire logic        I_SELECT_OUT,    // Select level when driven
   input  wire logic        I_SERIAL_OUT,    // Shifter output bit
   input  wire logic        I_CPU_WAIT,      // Processor in wait mode
   input  wire logic        I_SELECT_PIN,    // Select pin level
   input  wire logic        I_MASTER_PIN,    // Master-out pin level
   input  wire logic        I_SLAVE_PIN,     // Slave-out pin level
   output logic             O_SELECT_OUT,    // Select pin drive value
   output logic             O_SELECT_OE,     // Select pin drive enable
   output logic             O_SELECT_SPI,    // SPI owns the select pin
   output logic             O_SLAVE_SELECTED,// Slave select active
   output logic             O_FAULT_INPUT,   // Fault input asserted
   output logic             O_MASTER_OUT,    // Master-out drive value
   output logic             O_MASTER_OE,     // Master-out drive enable
   output logic             O_MASTER_SPI,    // SPI owns master-out pin
   output logic             O_SLAVE_OUT,     // Slave-out drive value
   output logic             O_SLAVE_OE,      // Slave-out drive enable
   output logic             O_SLAVE_SPI,     // SPI owns slave-out pin
   output logic             O_SERIAL_IN,     // Received data bit
   output logic             O_CLOCK_RUN,     // SPI clocks enabled
   output logic             O_BIT_TICK       // Master bit-rate pulse
);

   // Bus slave state
   logic       aw_got_r, aw_got_nxt;
   logic       w_got_r, w_got_nxt;
   logic [3:0] aw_addr_r, aw_addr_nxt;
   logic [7:0] w_data_r, w_data_nxt;
   logic       w_strb_r, w_strb_nxt;
   logic       bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic       rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [7:0] option_r, option_nxt;
   logic [7:0] rate_r, rate_nxt;

   // Pin synchronisers, first stage read only by second
   logic [2:0] pin_s1_r, pin_s2_r;

   // Rate generator state
   logic [2:0] pre_cnt_r, pre_cnt_nxt;
   logic [7:0] div_cnt_r, div_cnt_nxt;
   logic       tick_r, tick_nxt;

   // Pin function outputs
   logic sel_out_r, sel_out_nxt, sel_oe_r, sel_oe_nxt;
   logic sel_spi_r, sel_spi_nxt, slv_sel_r, slv_sel_nxt;
   logic fault_r, fault_nxt;
   logic mo_r, mo_nxt, mo_oe_r, mo_oe_nxt, mo_spi_r, mo_spi_nxt;
   logic so_r, so_nxt, so_oe_r, so_oe_nxt, so_spi_r, so_spi_nxt;
   logic sin_r, sin_nxt, run_r, run_nxt;

   logic fault_en, drive_en, single_wire, wait_stop;
   logic [2:0] prescale_code, rate_divide_code;
   logic [7:0] rate_mask;
   logic       do_write, pre_wrap;

   assign fault_en         = option_r[FAULT_EN_BIT];
   assign drive_en         = option_r[DRIVE_EN_BIT];
   assign wait_stop        = option_r[WAIT_STOP_BIT];
   assign single_wire      = option_r[SINGLE_WIRE_BIT];
   assign prescale_code    = rate_r[PRESCALE_LSB +: 3];
   assign rate_divide_code = rate_r[RATE_LSB +: 3];
   assign do_write = aw_got_r && w_got_r && !bvalid_r;

   // Register bus: address and data taken in either order
   always_comb begin
      aw_got_nxt  = aw_got_r;
      w_got_nxt   = w_got_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      option_nxt  = option_r;
      rate_nxt    = rate_r;
      if (I_AWVALID && !aw_got_r && !bvalid_r) begin
         aw_got_nxt  = 1'b1;
         aw_addr_nxt = I_AWADDR;
      end
      if (I_WVALID && !w_got_r && !bvalid_r) begin
         w_got_nxt  = 1'b1;
         w_data_nxt = I_WDATA[7:0];
         w_strb_nxt = I_WSTRB[0];
      end
      if (do_write) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = RESP_OKAY;
         if (aw_addr_r == OPTION_CONTROL_ADDR) begin
            if (w_strb_r)
               option_nxt = w_data_r & OPTION_WMASK;
         end else if (aw_addr_r == BIT_RATE_ADDR) begin
            if (w_strb_r)
               rate_nxt = w_data_r & BIT_RATE_WMASK;
         end else if (aw_addr_r != MODE_STATUS_ADDR) begin
            bresp_nxt = RESP_SLVERR;
         end
      end else if (bvalid_r && I_BREADY) begin
         bvalid_nxt = 1'b0;
      end
      if (I_ARVALID && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         case (I_ARADDR)
            OPTION_CONTROL_ADDR: rdata_nxt = {24'h000000, option_r};
            BIT_RATE_ADDR:       rdata_nxt = {24'h000000, rate_r};
            MODE_STATUS_ADDR:    rdata_nxt = {26'h0000000, run_r,
                                   fault_r, slv_sel_r, sin_r,
                                   so_oe_r, mo_oe_r};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && I_RREADY) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r  <= 8'h00;
         w_strb_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h00000000;
         option_r  <= OPTION_RESET;
         rate_r    <= BIT_RATE_RESET;
      end else begin
         aw_got_r  <= aw_got_nxt;
         w_got_r   <= w_got_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         option_r  <= option_nxt;
         rate_r    <= rate_nxt;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         pin_s1_r <= 3'h7;
         pin_s2_r <= 3'h7;
      end else begin
         pin_s1_r <= {I_SELECT_PIN, I_MASTER_PIN, I_SLAVE_PIN};
         pin_s2_r <= pin_s1_r;
      end
   end

   // Rate generator: prescaler by code+1, divider by 2^(code+1).
   // Counters restart when stopped, so a new setting takes effect
   // at once; a write mid-transfer may stretch one bit period.
   always_comb begin
      rate_mask   = 8'((9'h002 << rate_divide_code) - 9'h001);
      pre_wrap    = (pre_cnt_r >= prescale_code);
      pre_cnt_nxt = pre_cnt_r;
      div_cnt_nxt = div_cnt_r;
      tick_nxt    = 1'b0;
      if (!run_r || !I_MASTER_SELECT) begin
         pre_cnt_nxt = 3'h0;
         div_cnt_nxt = 8'h00;
      end else if (pre_wrap) begin
         pre_cnt_nxt = 3'h0;
         if ((div_cnt_r & rate_mask) == rate_mask) begin
            div_cnt_nxt = 8'h00;
            tick_nxt    = 1'b1;
         end else begin
            div_cnt_nxt = div_cnt_r + 8'h01;
         end
      end else begin
         pre_cnt_nxt = pre_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         pre_cnt_r <= 3'h0;
         div_cnt_r <= 8'h00;
         tick_r    <= 1'b0;
      end else begin
         pre_cnt_r <= pre_cnt_nxt;
         div_cnt_r <= div_cnt_nxt;
         tick_r    <= tick_nxt;
      end
   end

   // Pin functions
   always_comb begin
      run_nxt     = !(wait_stop && I_CPU_WAIT);
      sel_out_nxt = 1'b1;
      sel_oe_nxt  = 1'b0;
      sel_spi_nxt = 1'b1;
      slv_sel_nxt = 1'b0;
      fault_nxt   = 1'b0;
      if (!I_MASTER_SELECT) begin
         slv_sel_nxt = !pin_s2_r[2];
      end else if (!fault_en) begin
         sel_spi_nxt = 1'b0;
      end else if (I_SELECT_OUT_EN) begin
         sel_oe_nxt  = 1'b1;
         sel_out_nxt = I_SELECT_OUT;
      end else begin
         fault_nxt = !pin_s2_r[2];
      end
      mo_nxt     = I_SERIAL_OUT;
      so_nxt     = I_SERIAL_OUT;
      mo_oe_nxt  = 1'b0;
      so_oe_nxt  = 1'b0;
      mo_spi_nxt = 1'b1;
      so_spi_nxt = 1'b1;
      if (!single_wire) begin
         mo_oe_nxt = I_MASTER_SELECT;
         so_oe_nxt = !I_MASTER_SELECT && slv_sel_nxt;
         sin_nxt   = I_MASTER_SELECT ? pin_s2_r[0] : pin_s2_r[1];
      end else if (I_MASTER_SELECT) begin
         mo_oe_nxt  = drive_en;
         so_spi_nxt = 1'b0;
         sin_nxt    = pin_s2_r[1];
      end else begin
         so_oe_nxt  = drive_en;
         mo_spi_nxt = 1'b0;
         sin_nxt    = pin_s2_r[0];
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sel_out_r <= 1'b1;
         sel_oe_r  <= 1'b0;
         sel_spi_r <= 1'b1;
         slv_sel_r <= 1'b0;
         fault_r   <= 1'b0;
         mo_r      <= 1'b0;
         mo_oe_r   <= 1'b0;
         mo_spi_r  <= 1'b1;
         so_r      <= 1'b0;
         so_oe_r   <= 1'b0;
         so_spi_r  <= 1'b1;
         sin_r     <= 1'b0;
         run_r     <= 1'b1;
      end else begin
         sel_out_r <= sel_out_nxt;
         sel_oe_r  <= sel_oe_nxt;
         sel_spi_r <= sel_spi_nxt;
         slv_sel_r <= slv_sel_nxt;
         fault_r   <= fault_nxt;
         mo_r      <= mo_nxt;
         mo_oe_r   <= mo_oe_nxt;
         mo_spi_r  <= mo_spi_nxt;
         so_r      <= so_nxt;
         so_oe_r   <= so_oe_nxt;
         so_spi_r  <= so_spi_nxt;
         sin_r     <= sin_nxt;
         run_r     <= run_nxt;
      end
   end

   // Ready flags are registered so every output leaves a flip-flop
   logic awready_r, wready_r, arready_r;
   always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         arready_r <= 1'b0;
      end else begin
         awready_r <= I_AWVALID && !aw_got_r && !bvalid_r && !awready_r;
         wready_r  <= I_WVALID && !w_got_r && !bvalid_r && !wready_r;
         arready_r <= I_ARVALID && !rvalid_r && !arready_r;
      end
   end

   assign O_AWREADY        = awready_r;
   assign O_WREADY         = wready_r;
   assign O_BRESP          = bresp_r;
   assign O_BVALID         = bvalid_r;
   assign O_ARREADY        = arready_r;
   assign O_RDATA          = rdata_r;
   assign O_RRESP          = rresp_r;
   assign O_RVALID         = rvalid_r;
   assign O_SELECT_OUT     = sel_out_r;
   assign O_SELECT_OE      = sel_oe_r;
   assign O_SELECT_SPI     = sel_spi_r;
   assign O_SLAVE_SELECTED = slv_sel_r;
   assign O_FAULT_INPUT    = fault_r;
   assign O_MASTER_OUT     = mo_r;
   assign O_MASTER_OE      = mo_oe_r;
   assign O_MASTER_SPI     = mo_spi_r;
   assign O_SLAVE_OUT      = so_r;
   assign O_SLAVE_OE       = so_oe_r;
   assign O_SLAVE_SPI      = so_spi_r;
   assign O_SERIAL_IN      = sin_r;
   assign O_CLOCK_RUN      = run_r;
   assign O_BIT_TICK       = tick_r;

endmodule

// ### dv/spi_opt_ctrl_monitor.sv
// Checker on the pin and rate outputs of the option control block.
// Assumes it is bound to spi_opt_ctrl with every port named.
`timescale 1ns/100ps
module spi_opt_ctrl_monitor (
   input wire logic I_MCLK, I_RESET_N, I_MASTER_SELECT, I_SELECT_OUT_EN,
   input wire logic I_SELECT_OUT, I_SERIAL_OUT, I_CPU_WAIT, O_SELECT_OUT,
   input wire logic O_SELECT_OE, O_SELECT_SPI, O_FAULT_INPUT, O_MASTER_OE,
   input wire logic O_SLAVE_OUT, O_SLAVE_OE, O_CLOCK_RUN, O_BIT_TICK,
   input wire logic O_MASTER_OUT
);
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RESET_N);
   // Three slave cycles let a tick already in flight drain
   a_tick_idle: assert property (
      !I_MASTER_SELECT [*3] |=> !O_BIT_TICK)
      else $error("tick seen in slave mode");
   a_tick_once: assert property (O_BIT_TICK |=> !O_BIT_TICK)
      else $error("tick longer than one cycle");
   a_run_awake: assert property (!I_CPU_WAIT |=> O_CLOCK_RUN)
      else $error("clocks stopped outside wait");
   a_slave_sel: assert property (
      !I_MASTER_SELECT |=> O_SELECT_SPI && !O_SELECT_OE)
      else $error("select pin not an input in slave mode");
   a_fault_cause: assert property (
      O_FAULT_INPUT |-> $past(I_MASTER_SELECT && !I_SELECT_OUT_EN))
      else $error("fault input outside its mode");
   a_sel_drive: assert property (
      O_SELECT_OE |-> O_SELECT_SPI && $past(I_SELECT_OUT_EN)
         && O_SELECT_OUT == $past(I_SELECT_OUT))
      else $error("select output driven wrongly");
   a_slave_data: assert property (
      O_SLAVE_OE |-> $past(!I_MASTER_SELECT)
         && O_SLAVE_OUT == $past(I_SERIAL_OUT))
      else $error("slave data pin driven wrongly");
   a_master_data: assert property (
      O_MASTER_OE |-> $past(I_MASTER_SELECT)
         && O_MASTER_OUT == $past(I_SERIAL_OUT))
      else $error("master data pin driven wrongly");
   a_one_drive: assert property (!(O_MASTER_OE && O_SLAVE_OE))
      else $error("both data pins driven");
endmodule

// ### dv/spi_pin_partner.sv
// Far-side SPI device on the select pin and the two data pins.
// Assumes block drive enables are high while the block drives a pin.
`timescale 1ns/100ps
module spi_pin_partner (
   input  wire logic i_sel_oe,  // Block drives select
   input  wire logic i_sel_val, // Block select level
   input  wire logic i_mst_oe,  // Block drives master-out
   input  wire logic i_mst_val, // Block master-out level
   input  wire logic i_slv_oe,  // Block drives slave-out
   input  wire logic i_slv_val, // Block slave-out level
   input  wire logic i_sel_low, // Far side pulls select low
   input  wire logic i_data,    // Far side data bit
   output logic      o_sel,     // Select wire
   output logic      o_mst,     // Master-out wire
   output logic      o_slv      // Slave-out wire
);
   // Select has a pull-up; the far side keeps both data wires driven,
   // the slave wire inverted so the block's choice of pin shows
   assign o_sel = i_sel_oe ? i_sel_val : !i_sel_low;
   assign o_mst = i_mst_oe ? i_mst_val : i_data;
   assign o_slv = i_slv_oe ? i_slv_val : !i_data;
endmodule

// ### dv/spi_opt_ctrl_bench.sv
// Self-checking bench for the option control and bit-rate block.
// Assumes the register map and latencies of the spi_opt_pkg package.
`timescale 1ns/100ps
module spi_opt_ctrl_bench;
   import spi_opt_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
   logic arv = 1'b0, rry = 1'b0, mst = 1'b0, soe = 1'b0, cpuw = 1'b0;
   logic sel_low = 1'b0, ser = 1'b0, awry, wry, bv, arry, rv, so_v;
   logic so_oe, so_spi, ssel, flt, mo, mo_oe, mo_spi, sd, sd_oe, sd_spi;
   logic sin, run, tick, psel, pmst, pslv;
   logic [3:0] aw = 4'h0;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] br, rr;
   int err_total = 0, tests_run = 0, cyc = 0;

   spi_opt_ctrl i_dut (
      .I_MCLK(clk), .I_RESET_N(rst_n), .I_AWADDR(aw), .I_AWVALID(awv),
      .O_AWREADY(awry), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv),
      .O_WREADY(wry), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bry),
      .I_ARADDR(aw), .I_ARVALID(arv), .O_ARREADY(arry), .O_RDATA(rd),
      .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rry), .I_MASTER_SELECT(mst),
      .I_SELECT_OUT_EN(soe), .I_SELECT_OUT(!ser), .I_SERIAL_OUT(ser),
      .I_CPU_WAIT(cpuw), .I_SELECT_PIN(psel), .I_MASTER_PIN(pmst),
      .I_SLAVE_PIN(pslv), .O_SELECT_OUT(so_v), .O_SELECT_OE(so_oe),
      .O_SELECT_SPI(so_spi), .O_SLAVE_SELECTED(ssel), .O_FAULT_INPUT(flt),
      .O_MASTER_OUT(mo), .O_MASTER_OE(mo_oe), .O_MASTER_SPI(mo_spi),
      .O_SLAVE_OUT(sd), .O_SLAVE_OE(sd_oe), .O_SLAVE_SPI(sd_spi),
      .O_SERIAL_IN(sin), .O_CLOCK_RUN(run), .O_BIT_TICK(tick));
   spi_pin_partner i_far (.i_sel_oe(so_oe), .i_sel_val(so_v),
      .i_mst_oe(mo_oe), .i_mst_val(mo), .i_slv_oe(sd_oe), .i_slv_val(sd),
      .i_sel_low(sel_low), .i_data(1'b1), .o_sel(psel), .o_mst(pmst),
      .o_slv(pslv));

   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // One write or one read; the answer is awaited, never counted on
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] d, input logic [1:0] r);
      int n;
      n = 0;
      aw <= a;
      wd <= {24'h0, d};
      awv <= w;
      wv <= w;
      bry <= w;
      arv <= !w;
      rry <= !w;
      do begin
         @(posedge clk);
         if (awry) awv <= 1'b0;
         if (wry) wv <= 1'b0;
         if (arry) arv <= 1'b0;
         n++;
      end while ((w ? bv : rv) !== 1'b1 && n < 50);
      chkb("answer", 1'b1, w ? bv : rv);
      bry <= 1'b0;
      rry <= 1'b0;
      chk("resp", {30'h0, r}, {30'h0, w ? br : rr});
      if (!w) chk("rdata", {24'h0, d}, rd);
      @(posedge clk);
   endtask
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tick !== 1'b1 && n < 5000);
   endtask

   task automatic t_regs();
      bus(1'b0, OPTION_CONTROL_ADDR, 8'h00, RESP_OKAY);
      bus(1'b0, BIT_RATE_ADDR, 8'h00, RESP_OKAY);
      bus(1'b1, OPTION_CONTROL_ADDR, 8'hFF, RESP_OKAY);
      bus(1'b0, OPTION_CONTROL_ADDR, 8'h1B, RESP_OKAY);
      bus(1'b1, BIT_RATE_ADDR, 8'hFF, RESP_OKAY);
      bus(1'b0, BIT_RATE_ADDR, 8'h77, RESP_OKAY);
      bus(1'b1, 4'hC, 8'h5A, RESP_SLVERR);
      bus(1'b0, 4'hC, 8'h00, RESP_SLVERR);
   endtask
   task automatic t_pins();
      logic m, s, f, w, d;
      sel_low <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         {m, s, f, w, d} = 5'(i);
         mst <= m;
         soe <= s;
         bus(1'b1, OPTION_CONTROL_ADDR, {3'h0, f, d, 2'h0, w}, RESP_OKAY);
         repeat (6) @(posedge clk);
         chkb("sel_spi", !m | f, so_spi);
         chkb("sel_oe", m & f & s, so_oe);
         chkb("fault", m & f & !s, flt);
         chkb("slv_sel", !m, ssel);
         chkb("m_oe", m & (!w | d), mo_oe);
         chkb("s_oe", !m & (!w | d), sd_oe);
         chkb("s_spi", !(m & w), sd_spi);
         chkb("m_spi", m | !w, mo_spi);
         if (!(w & d)) chkb("s_in", !(m ^ w), sin);
      end
      mst <= 1'b0;
      soe <= 1'b0;
   endtask
   task automatic t_wait();
      cpuw <= 1'b1;
      repeat (3) @(posedge clk);
      chkb("run", 1'b1, run);
      bus(1'b1, OPTION_CONTROL_ADDR, 8'h02, RESP_OKAY);
      repeat (2) @(posedge clk);
      chkb("run", 1'b0, run);
      cpuw <= 1'b0;
      repeat (3) @(posedge clk);
      chkb("run", 1'b1, run);
      // Slave, two-wire, selected: run, selected, data in 1, slave oe
      bus(1'b1, MODE_STATUS_ADDR, 8'hFF, RESP_OKAY);
      bus(1'b0, MODE_STATUS_ADDR, 8'h2E, RESP_OKAY);
   endtask
   task automatic t_rate();
      logic [7:0] codes [5] = '{8'h00, 8'h07, 8'h70, 8'h25, 8'h77};
      int n;
      mst <= 1'b1;
      // Rate changes land while ticking; the first two gaps are discarded
      foreach (codes[k]) begin
         bus(1'b1, BIT_RATE_ADDR, codes[k], RESP_OKAY);
         repeat (3) wait_tick(n);
         chk("gap", (codes[k][6:4] + 1) << (codes[k][2:0] + 1), n);
      end
      mst <= 1'b0;
   endtask

   always #25 clk = ~clk;
   always @(posedge clk) ser <= !ser;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_pins();
      t_wait();
      t_rate();
      close_out();
   end
endmodule
bind spi_opt_ctrl spi_opt_ctrl_monitor i_mon (.I_MCLK(I_MCLK),
   .I_RESET_N(I_RESET_N), .I_MASTER_SELECT(I_MASTER_SELECT),
   .I_SELECT_OUT_EN(I_SELECT_OUT_EN), .I_SELECT_OUT(I_SELECT_OUT),
   .I_SERIAL_OUT(I_SERIAL_OUT), .I_CPU_WAIT(I_CPU_WAIT),
   .O_SELECT_OUT(O_SELECT_OUT), .O_SELECT_OE(O_SELECT_OE),
   .O_SELECT_SPI(O_SELECT_SPI), .O_FAULT_INPUT(O_FAULT_INPUT),
   .O_MASTER_OE(O_MASTER_OE), .O_SLAVE_OUT(O_SLAVE_OUT),
   .O_MASTER_OUT(O_MASTER_OUT),
   .O_SLAVE_OE(O_SLAVE_OE), .O_CLOCK_RUN(O_CLOCK_RUN),
   .O_BIT_TICK(O_BIT_TICK));
